// *** sleep_controller.sv ***
// Purpose: sleep mode controller with gated clock domains and wake timing
// Assumes: cpu pulses sleep_instr_i; clock controller reports osc ready
// Notes: wake sources come from enabled, unmasked interrupt requests
`timescale 1ns/10ps
module sleep_controller
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // control bits written by software
    input wire logic [2:0] ctrl_i,
    input wire sleep_pkg::standby_run_s run_in_standby_i,
    input wire logic global_irq_en_i,
    input wire logic [1:0] brownout_config_fuse_i,
    input wire logic bod_or_wdt_uses_ulp_i,
    // cpu side
    input wire logic sleep_instr_i,
    input wire logic debug_break_i,
    // interrupt sources, enabled requests, asynchronous
    input wire sleep_pkg::wake_src_s wake_src_i,
    // clock controller status, asynchronous
    input wire logic main_osc_ready_i,
    input wire logic brownout_ready_i,
    // outputs
    output logic cpu_halt_o,
    output logic asleep_o,
    output logic [1:0] active_mode_o,
    output sleep_pkg::domain_en_s domain_en_o,
    output logic [2:0] ctrl_o
);
    logic [2:0] ctrl_q;
    logic [1:0] mode_q;
    logic [2:0] wake_cnt_q;
    logic osc_stopped_q;
    sleep_pkg::sleep_state_e state_q;
    sleep_pkg::sleep_state_e state_d;
    sleep_pkg::wake_src_s src_s;
    logic osc_ready_s;
    logic bod_ready_s;
    logic brk_s;
    logic wake_s;
    logic bod_wait_s;
    logic enter_s;
    logic [1:0] sel_mode;
    logic sel_en;
    sleep_pkg::domain_en_s dom_d;

    // asynchronous sources cross through two flops each
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_src
            sync2 u_sync
            (
                .clock_i(clock_i),
                .reset_i(reset_i),
                .async_i(wake_src_i[gi]),
                .sync_o(src_s[gi])
            );
        end
    endgenerate

    sync2 u_osc
    (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .async_i(main_osc_ready_i),
        .sync_o(osc_ready_s)
    );

    sync2 u_bod
    (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .async_i(brownout_ready_i),
        .sync_o(bod_ready_s)
    );

    sync2 u_brk
    (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .async_i(debug_break_i),
        .sync_o(brk_s)
    );

    wake_filter u_filter
    (
        .mode_i(mode_q),
        .run_i(run_in_standby_i),
        .src_i(src_s),
        .wake_o(wake_s)
    );

    assign sel_mode =
        ctrl_q[sleep_pkg::CTRL_MODE_MSB:sleep_pkg::CTRL_MODE_LSB];
    assign sel_en = ctrl_q[sleep_pkg::CTRL_ENABLE_BIT];
    // disabled enable makes the instruction a no-operation
    assign enter_s = sleep_instr_i & sel_en;
    // a brownout already ready adds no cycle to the wake time
    assign bod_wait_s = (brownout_config_fuse_i == sleep_pkg::BOD_WAIT_CODE)
        && !bod_ready_s;

    // control register copy, read-write, reset zero
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ctrl_q <= sleep_pkg::CTRL_RESET;
        end
        else
        begin
            ctrl_q <= ctrl_i;
        end
    end

    // next state; only reset or debug break leaves sleep when no interrupt may wake
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            sleep_pkg::ST_ACTIVE:
            begin
                if (enter_s)
                begin
                    state_d = sleep_pkg::ST_SLEEP;
                end
            end
            sleep_pkg::ST_SLEEP:
            begin
                if (brk_s || (wake_s && global_irq_en_i))
                begin
                    if (osc_stopped_q)
                    begin
                        state_d = sleep_pkg::ST_OSC_WAIT;
                    end
                    else
                    begin
                        state_d = sleep_pkg::ST_WAKE_COUNT;
                    end
                end
            end
            sleep_pkg::ST_OSC_WAIT:
            begin
                if (osc_ready_s)
                begin
                    state_d = sleep_pkg::ST_WAKE_COUNT;
                end
            end
            sleep_pkg::ST_WAKE_COUNT:
            begin
                if (wake_cnt_q == 3'h0)
                begin
                    if (bod_wait_s)
                    begin
                        state_d = sleep_pkg::ST_BOD_WAIT;
                    end
                    else
                    begin
                        state_d = sleep_pkg::ST_ACTIVE;
                    end
                end
            end
            sleep_pkg::ST_BOD_WAIT:
            begin
                if (bod_ready_s)
                begin
                    state_d = sleep_pkg::ST_ACTIVE;
                end
            end
            default:
            begin
                state_d = sleep_pkg::ST_ACTIVE;
            end
        endcase
    end

    // state register; runs on the peripheral clock
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_q <= sleep_pkg::ST_ACTIVE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // mode captured at entry, held through the whole sleep
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            mode_q <= sleep_pkg::MODE_IDLE;
        end
        else if (state_q == sleep_pkg::ST_ACTIVE && enter_s)
        begin
            mode_q <= sel_mode;
        end
    end

    // whether wake must wait for the main oscillator to restart
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            osc_stopped_q <= 1'b0;
        end
        else if (state_q == sleep_pkg::ST_ACTIVE && enter_s)
        begin
            osc_stopped_q <= (sel_mode != sleep_pkg::MODE_IDLE)
                && !(sel_mode == sleep_pkg::MODE_STANDBY
                && run_in_standby_i.main_osc);
        end
    end

    // six cycle wake counter
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            wake_cnt_q <= sleep_pkg::WAKE_COUNT;
        end
        else if (state_q == sleep_pkg::ST_WAKE_COUNT)
        begin
            wake_cnt_q <= wake_cnt_q - 3'h1;
        end
        else
        begin
            wake_cnt_q <= sleep_pkg::WAKE_COUNT;
        end
    end

    // domain enables for the mode in force
    always_comb
    begin
        dom_d = '1;
        if (state_q == sleep_pkg::ST_SLEEP
            || state_q == sleep_pkg::ST_OSC_WAIT)
        begin
            dom_d.cpu_clk = 1'b0;
            case (mode_q)
                sleep_pkg::MODE_IDLE:
                begin
                    dom_d.peripheral_clock = 1'b1;
                end
                sleep_pkg::MODE_STANDBY:
                begin
                    dom_d.peripheral_clock = 1'b0;
                    dom_d.rtc_clk = run_in_standby_i.rtc;
                    dom_d.adc_touch_clk = run_in_standby_i.adc_touch;
                    dom_d.main_osc = run_in_standby_i.main_osc;
                    dom_d.rtc_osc = run_in_standby_i.rtc_osc;
                end
                default:
                begin
                    dom_d.peripheral_clock = 1'b0;
                    dom_d.rtc_clk = 1'b0;
                    dom_d.adc_touch_clk = 1'b0;
                    dom_d.main_osc = 1'b0;
                    dom_d.rtc_osc = bod_or_wdt_uses_ulp_i;
                    dom_d.ulp_osc = bod_or_wdt_uses_ulp_i;
                end
            endcase
            // oscillator request raised once wake-up begins
            if (state_q == sleep_pkg::ST_OSC_WAIT)
            begin
                dom_d.main_osc = 1'b1;
            end
        end
    end

    // halt from next state so the cpu stops on the very next edge
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            cpu_halt_o <= 1'b0;
        end
        else
        begin
            cpu_halt_o <= (state_d != sleep_pkg::ST_ACTIVE);
        end
    end

    // asleep drops one clock after the wake sequence starts, registered from the state
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            asleep_o <= 1'b0;
        end
        else
        begin
            asleep_o <= (state_q == sleep_pkg::ST_SLEEP);
        end
    end

    // mode in force, as captured at entry
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            active_mode_o <= sleep_pkg::MODE_IDLE;
        end
        else
        begin
            active_mode_o <= mode_q;
        end
    end

    // domain enables, everything on out of reset
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            domain_en_o <= '1;
        end
        else
        begin
            domain_en_o <= dom_d;
        end
    end

    // control readback
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            ctrl_o <= sleep_pkg::CTRL_RESET;
        end
        else
        begin
            ctrl_o <= ctrl_q;
        end
    end
endmodule

// *** sleep_pkg.sv ***
// Purpose: constants and types shared by the sleep controller files
// Assumes: one peripheral clock at 40 MHz, synchronous active-high reset
// Notes: control bits arrive as plain ports, no register bus
// Summary of operation
// - one active mode plus idle, standby and power down sleep modes
// - sleep needs mode chosen, enable set, then a sleep instruction
// - entering sleep halts the cpu and gates excluded clock domains
// - allowed interrupt wakes the cpu, which runs its handler and resumes
// - any reset ends sleep
// - debug break wakes the device even without pending interrupt
// - with no enabled wake interrupt only reset or debug break ends sleep
// - idle stops cpu only; any interrupt wakes
// - standby keeps rtc, adc/touch, oscillators only if run in standby set
// - standby wakes on pin, two-wire, timer, capture, gated peripheral irqs
// - power down keeps only watchdog and periodic interrupt timer
// - power down wakes on pin change, two-wire match, periodic timer
// - wake latency is six clocks plus oscillator start-up
// - idle wake adds no oscillator start-up
// - standby adds start-up only if main oscillator was stopped
// - power down runs only low-power 32 kHz and rtc clock if used
// - brownout fuse 0x3 extends wake until brownout detector ready
// - controller runs on the peripheral clock
// - mode codes: idle 0x0, standby 0x1, power down 0x2, rest reserved
// - control: mode at bits 2:1, enable at bit 0, reset zero
package sleep_pkg;
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h2;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_MODE_MSB = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [1:0] BOD_WAIT_CODE = 2'h3;
    localparam int WAKE_CYCLES = 6;
    localparam logic [2:0] WAKE_COUNT = 3'(WAKE_CYCLES - 1);

    typedef enum logic [2:0]
    {
        ST_ACTIVE,
        ST_SLEEP,
        ST_OSC_WAIT,
        ST_WAKE_COUNT,
        ST_BOD_WAIT
    } sleep_state_e;

    typedef struct packed
    {
        logic pin_irq;
        logic two_wire_port_match;
        logic periodic_interrupt_timer_irq;
        logic capture_timer_irq;
        logic usart_frame_irq;
        logic adc_window_irq;
        logic rtc_irq;
        logic other_irq;
    } wake_src_s;

    typedef struct packed
    {
        logic rtc;
        logic adc_touch;
        logic main_osc;
        logic rtc_osc;
        logic usart;
    } standby_run_s;

    typedef struct packed
    {
        logic cpu_clk;
        logic peripheral_clock;
        logic rtc_clk;
        logic adc_touch_clk;
        logic periodic_interrupt_timer_clk;
        logic watchdog_clock;
        logic main_osc;
        logic rtc_osc;
        logic ulp_osc;
    } domain_en_s;
endpackage

// *** sync2.sv ***
// Purpose: two-flop level synchroniser
// Assumes: input is asynchronous to clock_i
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module sync2
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // level
    input wire logic async_i,
    output logic sync_o
);
    logic meta_q;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            meta_q <= 1'b0;
            sync_o <= 1'b0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// *** wake_filter.sv ***
// Purpose: decide which enabled interrupts may wake in the chosen mode
// Assumes: sources already synchronised, combinational only
// Notes: reserved modes treated like power down, the safest gating
`timescale 1ns/10ps
module wake_filter
(
    // configuration
    input wire logic [1:0] mode_i,
    input wire sleep_pkg::standby_run_s run_i,
    // sources
    input wire sleep_pkg::wake_src_s src_i,
    // result
    output logic wake_o
);
    always_comb
    begin
        case (mode_i)
            sleep_pkg::MODE_IDLE:
            begin
                wake_o = |src_i;
            end
            sleep_pkg::MODE_STANDBY:
            begin
                wake_o = src_i.pin_irq | src_i.two_wire_port_match
                    | src_i.periodic_interrupt_timer_irq
                    | src_i.capture_timer_irq
                    | (src_i.usart_frame_irq & run_i.usart)
                    | (src_i.adc_window_irq & run_i.adc_touch)
                    | (src_i.rtc_irq & run_i.rtc);
            end
            default:
            begin
                wake_o = src_i.pin_irq | src_i.two_wire_port_match
                    | src_i.periodic_interrupt_timer_irq;
            end
        endcase
    end
endmodule

// *** osc_model.sv ***
// Purpose: clock controller stand-in giving oscillator and brownout ready
// Assumes: counts restart whenever the main oscillator is switched off
// Notes: counts are short so that the run stays brief
`timescale 1ns/10ps
module osc_model
#(
    parameter int OSC_CYCLES = 8,
    parameter int BOD_CYCLES = 30
)
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // request
    input wire logic main_osc_en_i,
    // status
    output logic main_osc_ready_o,
    output logic brownout_ready_o
);
    int cnt_q;
    always_ff @(posedge clock_i)
    begin
        if (reset_i || !main_osc_en_i)
            cnt_q <= 0;
        else if (cnt_q < BOD_CYCLES)
            cnt_q <= cnt_q + 1;
    end
    // a stopped oscillator needs its start-up again
    assign main_osc_ready_o = main_osc_en_i && cnt_q >= OSC_CYCLES;
    assign brownout_ready_o = cnt_q >= BOD_CYCLES;
endmodule

// *** sleep_checker.sv ***
// Purpose: port-level assertions for the sleep controller
// Assumes: one clock domain, synchronous active-high reset
// Notes: wake windows allow for the synchroniser latency
`timescale 1ns/10ps
module sleep_checker
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // inputs
    input wire logic [2:0] ctrl_i,
    input wire sleep_pkg::standby_run_s run_in_standby_i,
    input wire logic global_irq_en_i,
    input wire logic [1:0] brownout_config_fuse_i,
    input wire logic bod_or_wdt_uses_ulp_i,
    input wire logic sleep_instr_i,
    input wire logic debug_break_i,
    input wire sleep_pkg::wake_src_s wake_src_i,
    input wire logic main_osc_ready_i,
    input wire logic brownout_ready_i,
    // outputs
    input wire logic cpu_halt_o,
    input wire logic asleep_o,
    input wire logic [1:0] active_mode_o,
    input wire sleep_pkg::domain_en_s domain_en_o,
    input wire logic [2:0] ctrl_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    sequence s_enter;
        sleep_instr_i && ctrl_o[0] && !cpu_halt_o;
    endsequence
    sequence s_halted;
        cpu_halt_o ##1 (cpu_halt_o && asleep_o);
    endsequence
    property p_enter;
        s_enter |=> s_halted;
    endproperty
    a_enter: assert property (p_enter)
        else $error("sleep not entered");
    property p_noop;
        sleep_instr_i && !ctrl_o[0] && !cpu_halt_o |=> !cpu_halt_o;
    endproperty
    a_noop: assert property (p_noop)
        else $error("sleep taken with enable clear");
    property p_cpu_off;
        asleep_o |-> !domain_en_o.cpu_clk;
    endproperty
    a_cpu_off: assert property (p_cpu_off)
        else $error("cpu clock runs in sleep");
    property p_idle;
        asleep_o && active_mode_o == sleep_pkg::MODE_IDLE |->
            domain_en_o.peripheral_clock && domain_en_o.main_osc;
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle gated a running domain");
    property p_standby;
        asleep_o && active_mode_o == sleep_pkg::MODE_STANDBY |->
            domain_en_o.rtc_clk == run_in_standby_i.rtc &&
            domain_en_o.adc_touch_clk == run_in_standby_i.adc_touch &&
            domain_en_o.main_osc == run_in_standby_i.main_osc;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby gating differs from run settings");
    property p_power_down_mode;
        asleep_o && active_mode_o == sleep_pkg::MODE_POWER_DOWN |->
            !domain_en_o.peripheral_clock && !domain_en_o.main_osc &&
            domain_en_o.watchdog_clock &&
            domain_en_o.periodic_interrupt_timer_clk &&
            domain_en_o.ulp_osc == bod_or_wdt_uses_ulp_i;
    endproperty
    a_power_down_mode: assert property (p_power_down_mode)
        else $error("power down gating wrong");
    property p_idle_wake;
        $fell(asleep_o) && active_mode_o == sleep_pkg::MODE_IDLE &&
            brownout_config_fuse_i != sleep_pkg::BOD_WAIT_CODE |->
            cpu_halt_o[*5] ##[1:3] !cpu_halt_o;
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("idle wake time wrong");
    property p_no_irq;
        (asleep_o && !global_irq_en_i && !debug_break_i)[*6] |=> asleep_o;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("woke with interrupts disabled");
    property p_pd_stay;
        (asleep_o && active_mode_o == sleep_pkg::MODE_POWER_DOWN &&
            !debug_break_i && (wake_src_i & 8'he0) == 8'h00)[*6]
            |=> asleep_o;
    endproperty
    a_pd_stay: assert property (p_pd_stay)
        else $error("power down woke on excluded source");
    property p_reset;
        $fell(reset_i) |-> !cpu_halt_o && !asleep_o && ctrl_o == 3'h0 &&
            domain_en_o == 9'h1ff;
    endproperty
    a_reset: assert property (p_reset)
        else $error("state after reset wrong");
endmodule
bind sleep_controller sleep_checker i_checker
(
    .clock_i(clock_i), .reset_i(reset_i), .ctrl_i(ctrl_i),
    .run_in_standby_i(run_in_standby_i), .global_irq_en_i(global_irq_en_i),
    .brownout_config_fuse_i(brownout_config_fuse_i),
    .bod_or_wdt_uses_ulp_i(bod_or_wdt_uses_ulp_i),
    .sleep_instr_i(sleep_instr_i), .debug_break_i(debug_break_i),
    .wake_src_i(wake_src_i), .main_osc_ready_i(main_osc_ready_i),
    .brownout_ready_i(brownout_ready_i), .cpu_halt_o(cpu_halt_o),
    .asleep_o(asleep_o), .active_mode_o(active_mode_o),
    .domain_en_o(domain_en_o), .ctrl_o(ctrl_o)
);

// *** testbench.sv ***
// Purpose: scenario testbench for the sleep controller
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes: oscillator counts shortened in the partner model
`timescale 1ns/10ps
module testbench;
    localparam int OSC_N = 8;
    localparam int BOD_N = 30;
    logic clock_i;
    logic reset_i;
    logic [2:0] ctrl_i;
    sleep_pkg::standby_run_s run_i;
    logic gie;
    logic [1:0] fuse;
    logic ulp_use;
    logic slp;
    logic brk;
    sleep_pkg::wake_src_s src;
    logic osc_rdy;
    logic bod_rdy;
    logic halt;
    logic asleep;
    logic [1:0] mode;
    sleep_pkg::domain_en_s dom;
    logic [2:0] ctrl_o;
    int fails;
    int checks_done;
    int n;
    sleep_controller i_dut
    (
        .clock_i(clock_i), .reset_i(reset_i), .ctrl_i(ctrl_i),
        .run_in_standby_i(run_i), .global_irq_en_i(gie),
        .brownout_config_fuse_i(fuse), .bod_or_wdt_uses_ulp_i(ulp_use),
        .sleep_instr_i(slp), .debug_break_i(brk), .wake_src_i(src),
        .main_osc_ready_i(osc_rdy), .brownout_ready_i(bod_rdy),
        .cpu_halt_o(halt), .asleep_o(asleep), .active_mode_o(mode),
        .domain_en_o(dom), .ctrl_o(ctrl_o)
    );
    osc_model #(.OSC_CYCLES(OSC_N), .BOD_CYCLES(BOD_N)) i_osc
    (
        .clock_i(clock_i), .reset_i(reset_i), .main_osc_en_i(dom.main_osc),
        .main_osc_ready_o(osc_rdy), .brownout_ready_o(bod_rdy)
    );
    task automatic chk(input string what, input logic [15:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock_i);
        #2;
    endtask
    // mode and enable are set before the instruction
    task automatic enter(input logic [1:0] m);
        ctrl_i = {m, 1'b1};
        tick(2);
        slp = 1'b1;
        tick(1);
        slp = 1'b0;
        tick(2);
        chk("asleep", asleep, 1'b1);
        chk("mode", mode, m);
    endtask
    // source held until the cpu runs, as the synchroniser needs
    task automatic wake(input sleep_pkg::wake_src_s s);
        src = s;
        n = 0;
        while (halt === 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        src = '0;
        if (n >= 200)
        begin
            fails++;
            end_sim();
        end
    endtask
    // source left standing; the following wake replaces it
    task automatic stay(input sleep_pkg::wake_src_s s, input string what);
        src = s;
        tick(12);
        chk(what, asleep, 1'b1);
    endtask
    task automatic t_noop();
        ctrl_i = 3'h4;
        tick(2);
        slp = 1'b1;
        tick(1);
        slp = 1'b0;
        tick(2);
        chk("noop halt", halt, 1'b0);
        chk("ctrl copy", ctrl_o, 3'h4);
    endtask
    task automatic t_idle();
        enter(sleep_pkg::MODE_IDLE);
        chk("idle per", dom.peripheral_clock, 1'b1);
        chk("idle cpu", dom.cpu_clk, 1'b0);
        wake(8'h01);
        chk("idle wake", n inside {[9:12]}, 1'b1);
    endtask
    task automatic t_standby();
        run_i = 5'b10010;
        enter(sleep_pkg::MODE_STANDBY);
        chk("sb dom", {dom.rtc_clk, dom.adc_touch_clk}, 2'b10);
        stay(8'h08, "sb usart");
        wake(8'h10);
        chk("sb cold", n inside {[OSC_N+9:OSC_N+16]}, 1'b1);
        run_i = 5'b00100;
        enter(sleep_pkg::MODE_STANDBY);
        wake(8'h40);
        chk("sb warm", n inside {[9:12]}, 1'b1);
    endtask
    task automatic t_power_down_mode();
        for (int i = 5; i < 8; i++)
        begin
            ulp_use = i[0];
            enter(sleep_pkg::MODE_POWER_DOWN);
            chk("pd dom", {dom.peripheral_clock, dom.watchdog_clock},
                2'b01);
            chk("pd ulp", dom.ulp_osc, ulp_use);
            stay(8'h0f, "pd other");
            wake(8'(1 << i));
            chk("pd wake", n inside {[OSC_N+9:OSC_N+16]}, 1'b1);
        end
    endtask
    task automatic t_no_irq();
        gie = 1'b0;
        enter(sleep_pkg::MODE_IDLE);
        stay(8'h01, "no gie");
        brk = 1'b1;
        wake(8'h00);
        brk = 1'b0;
        chk("break wake", n inside {[9:14]}, 1'b1);
        enter(sleep_pkg::MODE_IDLE);
        reset_i = 1'b1;
        ctrl_i = 3'h0;
        tick(3);
        reset_i = 1'b0;
        tick(1);
        chk("reset wake", {halt, asleep, ctrl_o}, 5'h00);
        gie = 1'b1;
    endtask
    task automatic t_fuse();
        fuse = 2'h3;
        run_i = '0;
        enter(sleep_pkg::MODE_STANDBY);
        wake(8'h80);
        chk("bod wait", n inside {[BOD_N:BOD_N+12]}, 1'b1);
        fuse = 2'h0;
    endtask
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial
    begin
        fails = 0;
        checks_done = 0;
        reset_i = 1'b1;
        ctrl_i = 3'h0;
        run_i = '0;
        gie = 1'b1;
        fuse = 2'h0;
        ulp_use = 1'b1;
        slp = 1'b0;
        brk = 1'b0;
        src = '0;
        tick(3);
        reset_i = 1'b0;
        tick(1);
        chk("reset dom", dom, 9'h1ff);
        chk("reset ctrl", ctrl_o, 3'h0);
        t_noop();
        t_idle();
        t_standby();
        t_power_down_mode();
        t_no_irq();
        t_fuse();
        end_sim();
    end
endmodule
